//--- adcc_defs.svh
// Purpose: Constants for the converter control block
// Assumes: 50 MHz system clock
// Notes:   Field positions of the control/status byte
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
`define ADCC_RES_W        10
`define ADCC_SEL_W        4
`define ADCC_DONE_BIT     7
`define ADCC_SPEED_BIT    6
`define ADCC_ON_BIT       5
`define ADCC_DIV_SLOW     2'h3
`define ADCC_DIV_FAST     2'h1
`define ADCC_STEPS        4'h9
`define ADCC_SAMPLE_TICKS 4'h2
`define ADCC_UPPER_FULL   8'hff
`define ADCC_LOWER_FULL   8'h03
`define ADCC_LOWER_PAD    6'h00
`endif

//--- adcc_pkg.sv
// Purpose: Types for the converter control block
// Assumes: Used with adcc_defs.svh
// Notes:   Sequencer states only
package adcc_pkg;
  typedef enum logic [1:0] {
    ADCC_IDLE   = 2'b00,
    ADCC_SAMPLE = 2'b01,
    ADCC_CONV   = 2'b10
  } adcc_state_t;
endpackage

//--- adcc_clkdiv.sv
// Purpose: Converter clock enable from the system clock
// Assumes: Synchronous active low reset
// Notes:   Divide by four or by two
`timescale 1ns/1ps
`include "adcc_defs.svh"
module adcc_clkdiv (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic run,
  input  wire logic fast,
  output logic      tick
);
  logic [1:0] cnt_q;

  // Counts down, pulses at zero; held while not running
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !run) begin
      cnt_q <= `ADCC_DIV_SLOW;
      tick  <= 1'b0;
    end else if (cnt_q == 2'h0) begin
      cnt_q <= fast ? `ADCC_DIV_FAST : `ADCC_DIV_SLOW;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 2'h1;
      tick  <= 1'b0;
    end
  end
endmodule // adcc_clkdiv

//--- adcc_ctrl.sv
// Overview of operation
// - Successive approximation gives ten-bit result pair
// - Sixteen multiplexed inputs, any selectable
// - Above upper reference: FFh and 03h
// - Below lower reference: zero in both
// - Result code is monotonic with input
// - Power-on bit starts continuous conversion
// - Each end sets done flag, updates result
// - Upper register read clears done flag
// - New selection aborts, clears flag, restarts
// - Any control write clears done flag
// - Converter clock is system over four or two
// - Clearing power-on stops conversion
// - Upper holds bits 9:2, lower bits 1:0
//
// Purpose: Converter sequencer and result registers
// Assumes: Analog core gives comparator result per trial
// Notes:   Results are not latched against late reads
`timescale 1ns/1ps
`include "adcc_defs.svh"
module adcc_ctrl
  import adcc_pkg::*;
#(
  parameter int RES_W = `ADCC_RES_W,
  parameter int SEL_W = `ADCC_SEL_W
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             ctrl_wr,
  input  wire logic [7:0]       ctrl_wdata,
  input  wire logic             upper_rd,
  input  wire logic             cmp_above,
  output logic [7:0]            ctrl_rdata,
  output logic [7:0]            result_upper_reg,
  output logic [7:0]            result_lower_reg,
  output logic [RES_W-1:0]      dac_code,
  output logic [SEL_W-1:0]      input_selector,
  output logic                  sample_en,
  output logic                  converter_power_on
);
  adcc_state_t      state_q;
  logic             speed_q;
  logic             done_q;
  logic [3:0]       step_q;
  logic [RES_W-1:0] sar_q;
  logic             tick;
  logic             restart;

  // Channel change while running forces a fresh conversion
  assign restart = ctrl_wr && (ctrl_wdata[SEL_W-1:0] != input_selector);

  adcc_clkdiv adcc_clkdiv_inst (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .run     (converter_power_on),
    .fast    (speed_q),
    .tick    (tick)
  );

  // Control fields written by software
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      converter_power_on <= 1'b0;
      speed_q            <= 1'b0;
      input_selector     <= '0;
    end else if (ctrl_wr) begin
      converter_power_on <= ctrl_wdata[`ADCC_ON_BIT];
      speed_q            <= ctrl_wdata[`ADCC_SPEED_BIT];
      input_selector     <= ctrl_wdata[SEL_W-1:0];
    end
  end

  // Trial bit for the current step
  function automatic logic [RES_W-1:0] trial_bit(input logic [3:0] s);
    trial_bit = RES_W'(1) << s;
  endfunction

  // Successive approximation sequencer, restarted on channel change
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= ADCC_IDLE;
      step_q  <= '0;
      sar_q   <= '0;
    end else if (!converter_power_on || (ctrl_wr && !ctrl_wdata[`ADCC_ON_BIT])) begin
      state_q <= ADCC_IDLE;
    end else if (restart) begin
      state_q <= ADCC_SAMPLE;
      step_q  <= '0;
    end else begin
      case (state_q)
        ADCC_IDLE: begin
          state_q <= ADCC_SAMPLE;
          step_q  <= '0;
        end
        ADCC_SAMPLE: begin
          if (tick) begin
            if (step_q == `ADCC_SAMPLE_TICKS - 4'h1) begin
              state_q <= ADCC_CONV;
              step_q  <= `ADCC_STEPS;
              sar_q   <= trial_bit(`ADCC_STEPS);
            end else begin
              step_q <= step_q + 4'h1;
            end
          end
        end
        ADCC_CONV: begin
          if (tick) begin
            // Keep bit when input at or above trial, else drop it
            sar_q <= (cmp_above ? sar_q : (sar_q & ~trial_bit(step_q)))
                     | ((step_q != 4'h0) ? trial_bit(step_q - 4'h1) : '0);
            if (step_q == 4'h0) begin
              state_q <= ADCC_SAMPLE;
            end else begin
              step_q <= step_q - 4'h1;
            end
          end
        end
        default: state_q <= ADCC_IDLE;
      endcase
    end
  end

  logic             finish;
  logic [RES_W-1:0] final_code;
  // End of conversion; a write that keeps channel and power does not cancel it
  assign finish = converter_power_on && !restart && !(ctrl_wr && !ctrl_wdata[`ADCC_ON_BIT])
                  && state_q == ADCC_CONV && tick && step_q == 4'h0;
  // Saturation falls out: all trials kept give all ones, none gives zero
  assign final_code = cmp_above ? sar_q : (sar_q & ~trial_bit(4'h0));

  // Result registers split as 9:2 and 1:0
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      result_upper_reg <= '0;
      result_lower_reg <= '0;
    end else if (finish) begin
      result_upper_reg <= final_code[RES_W-1:2];
      result_lower_reg <= {`ADCC_LOWER_PAD, final_code[1:0]};
    end
  end

  // Done flag: set by end, cleared by upper read or control write; set wins
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (upper_rd || ctrl_wr) begin
      done_q <= 1'b0;
    end
  end

  // Status byte, analog drive
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_rdata <= '0;
      dac_code   <= '0;
      sample_en  <= 1'b0;
    end else begin
      ctrl_rdata <= {done_q, speed_q, converter_power_on, 1'b0, input_selector};
      dac_code   <= sar_q;
      sample_en  <= (state_q == ADCC_SAMPLE);
    end
  end

  // Checks
  upper_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (upper_rd && !finish) |=> !done_q) else $error("done flag not cleared by read");
  write_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ctrl_wr && !finish) |=> !done_q) else $error("done flag not cleared by write");
  done_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    finish |=> done_q && result_upper_reg == $past(final_code[RES_W-1:2])
               && result_lower_reg[1:0] == $past(final_code[1:0])) else $error("end missed");
  lower_pad_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    result_lower_reg[7:2] == `ADCC_LOWER_PAD) else $error("lower pad not zero");
  chan_abort_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (restart && converter_power_on && ctrl_wdata[`ADCC_ON_BIT])
    |=> state_q == ADCC_SAMPLE && step_q == 4'h0 && !done_q)
    else $error("channel change did not restart");
  off_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !converter_power_on |=> state_q == ADCC_IDLE) else $error("conversion ran while off");
  // Divider reload uses the speed bit as it stood one edge before the tick
  div_slow_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tick && !$past(speed_q) && converter_power_on) ##1 converter_power_on[*3]
    |=> tick) else $error("slow divide not four");
  div_fast_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tick && $past(speed_q) && converter_power_on) ##1 converter_power_on
    |-> !tick ##1 tick) else $error("fast divide not two");
  on_start_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_q == ADCC_IDLE && converter_power_on && !ctrl_wr) |=> state_q == ADCC_SAMPLE)
    else $error("power on did not start");
  full_c: cover property (@(posedge clk_sys) finish && final_code == 10'h3ff);
  zero_c: cover property (@(posedge clk_sys) finish && final_code == 10'h000);
  abort_c: cover property (@(posedge clk_sys) restart && state_q == ADCC_CONV);
  read_c: cover property (@(posedge clk_sys) done_q && upper_rd);
endmodule // adcc_ctrl

//--- adcc_core_model.sv
// Purpose: Analog core model, input mux with sample and hold
// Assumes: Levels are signed codes, negative below lower reference
// Notes:   Levels above 3ffh saturate the code
`timescale 1ns/1ps
module adcc_core_model (
  input  wire logic              clk_sys,
  input  wire logic [15:0][11:0] ain_level,
  input  wire logic [3:0]        input_selector,
  input  wire logic [9:0]        dac_code,
  input  wire logic              sample_en,
  output logic                   cmp_above
);
  logic [11:0] held_q;
  // Hold the selected input while sampling
  always_ff @(posedge clk_sys) begin
    if (sample_en) begin
      held_q <= ain_level[input_selector];
    end
  end
  // Comparator: held input at or above trial code
  assign cmp_above = $signed(held_q) >= $signed({2'b00, dac_code});
endmodule // adcc_core_model

//--- adcc_ctrl_tb_top.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Core model answers within one cycle
// Notes:   Table rows first, then clear, abort and stop cases
`timescale 1ns/1ps
module adcc_ctrl_tb_top;
  logic clk_sys, rst_b, ctrl_wr, upper_rd, cmp_above, sample_en, converter_power_on;
  logic [7:0] ctrl_wdata, ctrl_rdata, result_upper_reg, result_lower_reg;
  logic [9:0] dac_code;
  logic [3:0] input_selector;
  logic [15:0][11:0] ain_level;
  int num_errors, cmp_count, n;
  bit seen;
  typedef struct {logic [7:0] c; logic [11:0] v; logic [7:0] u; logic [7:0] l;} adcc_row_t;
  // Control byte, input level, expected upper and lower
  adcc_row_t rows [5] = '{'{8'h20, 12'h2aa, 8'haa, 8'h02}, '{8'h65, 12'h155, 8'h55, 8'h01},
    '{8'h2f, 12'h7d0, 8'hff, 8'h03}, '{8'h69, 12'hffb, 8'h00, 8'h00},
    '{8'h33, 12'h3ff, 8'hff, 8'h03}};
  adcc_ctrl adcc_ctrl_inst (.clk_sys(clk_sys), .rst_b(rst_b), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .upper_rd(upper_rd), .cmp_above(cmp_above),
    .ctrl_rdata(ctrl_rdata), .result_upper_reg(result_upper_reg),
    .result_lower_reg(result_lower_reg), .dac_code(dac_code),
    .input_selector(input_selector), .sample_en(sample_en),
    .converter_power_on(converter_power_on));
  adcc_core_model adcc_core_model_inst (.clk_sys(clk_sys), .ain_level(ain_level),
    .input_selector(input_selector), .dac_code(dac_code), .sample_en(sample_en),
    .cmp_above(cmp_above));
  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe, then one idle edge
  task automatic wr(input logic [7:0] b);
    @(posedge clk_sys);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= b;
    @(posedge clk_sys);
    ctrl_wr <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rd_upper();
    @(posedge clk_sys);
    upper_rd <= 1'b1;
    @(posedge clk_sys);
    upper_rd <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  // Bounded poll of the done flag
  task automatic wait_done(input int lim);
    seen = 0;
    for (n = 0; n < lim && !seen; n++) begin
      @(posedge clk_sys);
      #1 seen = (ctrl_rdata[7] === 1'b1);
    end
  endtask
  task automatic need_done();
    wait_done(300);
    if (!seen) begin
      num_errors++;
      conclude();
    end
  endtask
  initial begin
    rst_b = 1'b0;
    ctrl_wr = 1'b0;
    ctrl_wdata = 8'h00;
    upper_rd = 1'b0;
    for (int i = 0; i < 16; i++) ain_level[i] = 12'(i * 40 + 7);
    repeat (20) @(posedge clk_sys);
    #1 chk(ctrl_rdata, 8'h00);
    chk(result_upper_reg | result_lower_reg, 8'h00);
    $display("reset finished");
    @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (rows[r]) begin
      ain_level[rows[r].c[3:0]] = rows[r].v;
      wr(rows[r].c);
      need_done();
      chk(8'(n < 40), {7'h00, rows[r].c[6]});
      chk(ctrl_rdata, {1'b1, rows[r].c[6:5], 1'b0, rows[r].c[3:0]});
      chk({4'h0, input_selector}, {4'h0, rows[r].c[3:0]});
      chk(result_lower_reg, rows[r].l);
      chk(result_upper_reg, rows[r].u);
      rd_upper();
      chk({7'h00, ctrl_rdata[7]}, 8'h00);
      $display("row %0d finished", r);
    end
    need_done();
    wr(8'h33);
    chk({7'h00, ctrl_rdata[7]}, 8'h00);
    $display("control write clear finished");
    wr(8'h22);
    repeat (10) @(posedge clk_sys);
    wr(8'h27);
    need_done();
    chk(result_upper_reg, 8'h47);
    chk(result_lower_reg, 8'h03);
    $display("channel change finished");
    wr(8'h07);
    wait_done(300);
    chk({7'h00, seen}, 8'h00);
    chk({7'h00, converter_power_on}, 8'h00);
    $display("stop finished");
    // Reset in the middle of a conversion clears results and stops the sequencer
    wr(8'h25);
    repeat (30) @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk(ctrl_rdata, 8'h00);
    chk(result_upper_reg | result_lower_reg, 8'h00);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk({6'h00, sample_en, converter_power_on}, 8'h00);
    $display("mid-run reset finished");
    conclude();
  end
endmodule // adcc_ctrl_tb_top
